// ---- dv/mpu_core_assertions.sv ----
// Concurrent checks on the pointer unit ports
`timescale 1ns/1ps
module mpu_core_checker (
  // Clock and reset
  input logic REF_CLK,
  input logic RST,
  // Operations
  input logic OP_VALID,
  input logic [3:0] OP_CODE,
  input logic [15:0] OP_DATA,
  input logic OP_BUSY,
  input logic RES_VALID,
  // Memories and status
  input logic [15:0] FETCH_ADDR,
  input logic FETCH_STB,
  input logic PM_RE,
  input logic [15:0] SRAM_ADDR,
  input logic SRAM_RE,
  input logic SRAM_WE,
  input logic SRAM_BYTE,
  input logic SYS_PROG_FLAG,
  input logic [1:0] INT_SERVICE
);
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (RST);
  logic tk;
  assign tk = OP_VALID && !OP_BUSY;
  sequence s_take(logic [3:0] c);
    tk && OP_CODE == c;
  endsequence
  a_fetch_step: assert property (s_take(mpu_pkg::OP_FETCH) ##1 s_take(mpu_pkg::OP_FETCH) |-> FETCH_STB
    ##1 (FETCH_STB && FETCH_ADDR == $past(FETCH_ADDR) + 16'h0001)) else $error("fetch step wrong");
  a_jump_fetch: assert property (s_take(mpu_pkg::OP_JUMP) ##1 s_take(mpu_pkg::OP_FETCH) |=>
    FETCH_STB && FETCH_ADDR == $past(OP_DATA, 2)) else $error("jump not followed");
  a_load_one: assert property (s_take(mpu_pkg::OP_LOAD) |-> ##2 RES_VALID) else $error("load late");
  a_code_two: assert property (s_take(mpu_pkg::OP_CODE_READ) |=> (PM_RE && OP_BUSY) [*2]
    ##1 (!PM_RE && !OP_BUSY && RES_VALID)) else $error("code read timing");
  a_popint_bits: assert property (s_take(mpu_pkg::OP_POP_INT) |=> INT_SERVICE == 2'b11)
    else $error("service bits not set");
  a_push_pop: assert property (s_take(mpu_pkg::OP_PUSH) ##1 s_take(mpu_pkg::OP_POP) |-> SRAM_WE
    ##1 (SRAM_RE && SRAM_ADDR == $past(SRAM_ADDR))) else $error("push pop mismatch");
  a_pop_step: assert property (s_take(mpu_pkg::OP_POP) ##1 s_take(mpu_pkg::OP_POP) |-> SRAM_RE
    ##1 (SRAM_RE && SRAM_ADDR == $past(SRAM_ADDR) + 16'h0001)) else $error("pop step wrong");
  a_sram_range: assert property ((SRAM_RE || SRAM_WE) && !SRAM_BYTE |-> SRAM_ADDR <= 16'h03FF)
    else $error("word access out of range");
  a_we_cause: assert property (SRAM_WE |-> $past(tk && (OP_CODE == mpu_pkg::OP_STORE
    || OP_CODE == mpu_pkg::OP_PUSH))) else $error("write without store");
  a_flag_reset: assert property ($fell(RST) |-> !SYS_PROG_FLAG) else $error("flag not cleared");
endmodule
bind mpu_core mpu_core_checker i_mpu_core_checker (.REF_CLK(REF_CLK), .RST(RST), .OP_VALID(OP_VALID),
  .OP_CODE(OP_CODE), .OP_DATA(OP_DATA), .OP_BUSY(OP_BUSY), .RES_VALID(RES_VALID), .FETCH_ADDR(FETCH_ADDR),
  .FETCH_STB(FETCH_STB), .PM_RE(PM_RE), .SRAM_ADDR(SRAM_ADDR), .SRAM_RE(SRAM_RE), .SRAM_WE(SRAM_WE),
  .SRAM_BYTE(SRAM_BYTE), .SYS_PROG_FLAG(SYS_PROG_FLAG), .INT_SERVICE(INT_SERVICE));

// ---- dv/mpu_core_tb_top.sv ----
// Self-checking testbench for the pointer unit
`timescale 1ns/1ps
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin num_errors++; $display("BAD %0t got %h want %h", $time, a, b); end end
module mpu_core_tb_top;
  logic REF_CLK = 0;
  logic RST = 1;
  logic [5:0] av_a = 0;
  logic av_r = 0;
  logic av_w = 0;
  logic [31:0] av_d = 0;
  logic op_v = 0;
  logic [3:0] op_c = 0;
  logic [1:0] op_p = 0;
  logic [1:0] op_s = 0;
  logic [15:0] op_d = 0;
  logic jtag = 0;
  logic hold = 0;
  logic [31:0] rdata;
  logic wreq, busy, resv, fstb, pre, sre, swe, sb, flag;
  logic [15:0] resd, faddr, paddr, prd, sa, swd, srd, last_res, q, a, d, e;
  logic [1:0] isv;
  logic [15:0] fq[$];
  logic [31:0] seed = 32'h0000_07c7;
  int num_errors = 0;
  int cmp_count = 0;
  int cyc = 0;
  mpu_core i_mpu_core (.REF_CLK(REF_CLK), .RST(RST), .AVS_ADDRESS(av_a), .AVS_READ(av_r), .AVS_WRITE(av_w),
    .AVS_WRITEDATA(av_d), .AVS_BYTEENABLE(4'hf), .AVS_READDATA(rdata), .AVS_WAITREQUEST(wreq),
    .OP_VALID(op_v), .OP_CODE(op_c), .OP_PTR(op_p), .OP_STEP(op_s), .OP_DATA(op_d), .OP_BUSY(busy),
    .RES_VALID(resv), .RES_DATA(resd), .FETCH_ADDR(faddr), .FETCH_STB(fstb), .PM_ADDR(paddr), .PM_RE(pre),
    .PM_RDATA(prd), .SRAM_ADDR(sa), .SRAM_RE(sre), .SRAM_WE(swe), .SRAM_BYTE(sb), .SRAM_WDATA(swd),
    .SRAM_RDATA(srd), .JTAG_SPE_REQ(jtag), .SYS_HOLD(hold), .SYS_PROG_FLAG(flag), .INT_SERVICE(isv));
  mpu_mem_model i_mpu_mem_model (.REF_CLK(REF_CLK), .PM_ADDR(paddr), .PM_RE(pre), .PM_RDATA(prd),
    .SRAM_ADDR(sa), .SRAM_RE(sre), .SRAM_WE(swe), .SRAM_BYTE(sb), .SRAM_WDATA(swd), .SRAM_RDATA(srd));
  initial begin
    forever #10 REF_CLK = ~REF_CLK;
  end
  function logic [15:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[15:0];
  endfunction
  function logic [15:0] pm_exp(input logic [15:0] c);
    return {1'b0, c[14:0]} ^ 16'h3c5a;
  endfunction
  function logic [15:0] pm_exp_byte(input logic [15:0] c, input logic pg);
    logic [15:0] w;
    w = {1'b0, pg, c[14:1]} ^ 16'h3c5a;
    return c[0] ? {8'h00, w[15:8]} : {8'h00, w[7:0]};
  endfunction
  task bus(input logic w, input logic [5:0] ad, input logic [15:0] wd);
    av_a <= ad;
    av_r <= !w;
    av_w <= w;
    av_d <= {16'h0000, wd};
    do @(posedge REF_CLK); while (wreq !== 1'b0);
    q = rdata[15:0];
    av_r <= 0;
    av_w <= 0;
    @(posedge REF_CLK);
  endtask
  task chk_reg(input logic [5:0] ad, input logic [15:0] ex);
    bus(1'b0, ad, 16'h0000);
    `CHK(q, ex)
  endtask
  task op(input logic [3:0] c, input logic [1:0] p, input logic [1:0] s, input logic [15:0] dd);
    op_v <= 1;
    op_c <= c;
    op_p <= p;
    op_s <= s;
    op_d <= dd;
    @(posedge REF_CLK);
  endtask
  task idle(input int n);
    op_v <= 0;
    repeat (n) @(posedge REF_CLK);
  endtask
  task give_verdict();
    $display("compares %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // ==========================================================
  // Monitors and timeout
  always @(posedge REF_CLK) begin
    if (resv === 1'b1) last_res <= resd;
    if (fstb === 1'b1) fq.push_back(faddr);
    cyc++;
    if (cyc == 5000) begin
      num_errors++;
      give_verdict();
    end
  end
  // ==========================================================
  // Main sequence
  initial begin
    repeat (20) @(posedge REF_CLK);
    RST <= 0;
    @(posedge REF_CLK);
    chk_reg(mpu_pkg::OFS_FETCH, 16'h8000);
    chk_reg(mpu_pkg::OFS_STACK, 16'h03F0);
    chk_reg(mpu_pkg::OFS_CTRL, 16'h0001);
    chk_reg(6'h3C, 16'h0000);
    $display("test reset done");
    a = rnd() & 16'h7FFF;
    op(mpu_pkg::OP_FETCH, 2'h0, 2'h0, 16'h0000);
    op(mpu_pkg::OP_FETCH, 2'h0, 2'h0, 16'h0000);
    op(mpu_pkg::OP_JUMP, 2'h0, 2'h0, a);
    op(mpu_pkg::OP_FETCH, 2'h0, 2'h0, 16'h0000);
    idle(3);
    bus(1'b1, mpu_pkg::OFS_FETCH, 16'h0123);
    op(mpu_pkg::OP_FETCH, 2'h0, 2'h0, 16'h0000);
    idle(3);
    `CHK(fq[0], 16'h8000)
    `CHK(fq[1], 16'h8001)
    `CHK(fq[2], a)
    `CHK(fq[3], 16'h0123)
    chk_reg(mpu_pkg::OFS_FETCH, 16'h0124);
    $display("test fetch done");
    for (int i = 0; i < 8; i++) begin
      a = (rnd() % 16'h03EE) + 16'h0001;
      d = rnd();
      bus(1'b1, mpu_pkg::OFS_DP0 + {i[0], 2'b00}, a);
      op(mpu_pkg::OP_STORE, {1'b0, i[0]}, {i[1], !i[1]}, d);
      op(mpu_pkg::OP_LOAD, {1'b0, i[0]}, {!i[1], i[1]}, 16'h0000);
      idle(3);
      `CHK(last_res, d)
      chk_reg(mpu_pkg::OFS_DP0 + {i[0], 2'b00}, a);
    end
    $display("test pointers done");
    a = rnd() & 16'h03FF;
    d = rnd();
    bus(1'b1, mpu_pkg::OFS_BASE, a);
    bus(1'b1, mpu_pkg::OFS_OFFSET, 16'hFFFF);
    chk_reg(mpu_pkg::OFS_FRAME, a - 16'h0001);
    op(mpu_pkg::OP_STORE, 2'h2, 2'h1, d);
    idle(1);
    chk_reg(mpu_pkg::OFS_OFFSET, 16'h0000);
    chk_reg(mpu_pkg::OFS_BASE, a);
    op(mpu_pkg::OP_LOAD, 2'h2, 2'h1, 16'h0000);
    idle(3);
    `CHK(last_res, d)
    chk_reg(mpu_pkg::OFS_OFFSET, 16'h0001);
    $display("test frame done");
    a = rnd();
    bus(1'b1, mpu_pkg::OFS_CODE, a);
    op(mpu_pkg::OP_CODE_READ, 2'h0, 2'h1, 16'h0000);
    idle(4);
    `CHK(last_res, pm_exp(a))
    chk_reg(mpu_pkg::OFS_CODE, a + 16'h0001);
    $display("test code read done");
    a = rnd();
    d = rnd();
    e = rnd();
    op(mpu_pkg::OP_PUSH, 2'h0, 2'h0, a);
    op(mpu_pkg::OP_PUSH, 2'h0, 2'h0, d);
    op(mpu_pkg::OP_PUSH, 2'h0, 2'h0, e);
    op(mpu_pkg::OP_POP, 2'h0, 2'h0, 16'h0000);
    op(mpu_pkg::OP_POP, 2'h0, 2'h0, 16'h0000);
    idle(3);
    `CHK(last_res, d)
    op(mpu_pkg::OP_POP_INT, 2'h0, 2'h0, 16'h0000);
    idle(3);
    `CHK(last_res, a)
    `CHK(isv, 2'b11)
    chk_reg(mpu_pkg::OFS_STACK, 16'h03F0);
    bus(1'b1, mpu_pkg::OFS_CTRL, 16'h0000);
    a = 16'h0400 | (rnd() & 16'h03FF);
    d = rnd();
    bus(1'b1, mpu_pkg::OFS_DP0, a);
    op(mpu_pkg::OP_STORE, 2'h0, 2'h0, d);
    op(mpu_pkg::OP_LOAD, 2'h0, 2'h0, 16'h0000);
    idle(3);
    `CHK(last_res, {8'h00, d[7:0]})
    bus(1'b1, mpu_pkg::OFS_CTRL, 16'h0002);
    a = rnd();
    bus(1'b1, mpu_pkg::OFS_CODE, a);
    op(mpu_pkg::OP_CODE_READ, 2'h0, 2'h2, 16'h0000);
    idle(4);
    `CHK(last_res, pm_exp_byte(a, 1'b1))
    chk_reg(mpu_pkg::OFS_CODE, a - 16'h0001);
    bus(1'b1, mpu_pkg::OFS_CTRL, 16'h0001);
    chk_reg(mpu_pkg::OFS_CTRL, 16'h0001);
    $display("test stack and byte done");
    jtag <= 1;
    hold <= 1;
    repeat (5) @(posedge REF_CLK);
    `CHK(flag, 1'b1)
    chk_reg(mpu_pkg::OFS_CTRL, 16'h0009);
    $display("test flag done");
    jtag <= 0;
    hold <= 0;
    RST <= 1;
    repeat (3) @(posedge REF_CLK);
    RST <= 0;
    @(posedge REF_CLK);
    chk_reg(mpu_pkg::OFS_FETCH, 16'h8000);
    chk_reg(mpu_pkg::OFS_CTRL, 16'h0001);
    $display("test second reset done");
    give_verdict();
  end
endmodule

// ---- dv/mpu_mem_model.sv ----
// Program memory and data SRAM models behind the pointer unit
`timescale 1ns/1ps
module mpu_mem_model (
  // Clock
  input logic REF_CLK,
  // Program memory data read
  input logic [15:0] PM_ADDR,
  input logic PM_RE,
  output logic [15:0] PM_RDATA,
  // Data SRAM
  input logic [15:0] SRAM_ADDR,
  input logic SRAM_RE,
  input logic SRAM_WE,
  input logic SRAM_BYTE,
  input logic [15:0] SRAM_WDATA,
  output logic [15:0] SRAM_RDATA
);
  logic [15:0] mem [0:1023];
  logic [15:0] junk = 16'h5a5a;
  logic [9:0] wi;
  // Byte lanes share one word
  assign wi = SRAM_BYTE ? SRAM_ADDR[10:1] : SRAM_ADDR[9:0];
  // Program memory has fixed contents, no write path
  assign PM_RDATA = PM_RE ? (PM_ADDR ^ 16'h3c5a) : junk;
  assign SRAM_RDATA = SRAM_RE ? mem[wi] : junk;
  always @(posedge REF_CLK) begin
    junk <= ~junk + 16'h0001;
    if (SRAM_WE && !SRAM_BYTE) begin
      mem[wi] <= SRAM_WDATA;
    end
    if (SRAM_WE && SRAM_BYTE) begin
      mem[wi][{SRAM_ADDR[0], 3'b000} +: 8] <= SRAM_WDATA[7:0];
    end
  end
endmodule

// ---- include/mpu_pkg.sv ----
// Constants and types for the memory pointer unit
package mpu_pkg;

  // ==========================================================
  // Address map of the memories
  localparam logic [15:0] IP_RESET = 16'h8000;
  localparam logic [15:0] USER_START = 16'h0000;
  localparam logic [15:0] USER_TOP = 16'h7FFF;
  localparam logic [15:0] SRAM_WORD_TOP = 16'h03FF;
  localparam logic [15:0] SRAM_BYTE_TOP = 16'h07FF;
  localparam logic [15:0] SP_RESET = 16'h03F0;
  localparam logic [15:0] PTR_RESET = 16'h0000;
  localparam logic [15:0] STEP_ONE = 16'h0001;

  // ==========================================================
  // Control register fields and reset values
  localparam int CTRL_WORD_BIT = 0;
  localparam int CTRL_CDA0_BIT = 1;
  localparam int CTRL_CDA1_BIT = 2;
  localparam int CTRL_SPE_BIT = 3;
  localparam int CTRL_IPS_LSB = 4;
  localparam logic WORD_MODE_RESET = 1'b1;
  localparam logic CDA0_RESET = 1'b0;
  localparam logic SPE_RESET = 1'b0;
  localparam logic [1:0] IPS_RESET = 2'b00;
  localparam logic [1:0] IPS_ACTIVE = 2'b11;

  // ==========================================================
  // Timing
  localparam logic [1:0] CP_READ_CYCLES = 2'h2;

  // ==========================================================
  // Register byte offsets
  localparam logic [5:0] OFS_FETCH = 6'h00;
  localparam logic [5:0] OFS_DP0 = 6'h04;
  localparam logic [5:0] OFS_DP1 = 6'h08;
  localparam logic [5:0] OFS_BASE = 6'h0C;
  localparam logic [5:0] OFS_OFFSET = 6'h10;
  localparam logic [5:0] OFS_CODE = 6'h14;
  localparam logic [5:0] OFS_STACK = 6'h18;
  localparam logic [5:0] OFS_CTRL = 6'h1C;
  localparam logic [5:0] OFS_FRAME = 6'h20;
  localparam logic [5:0] OFS_STATUS = 6'h24;

  // ==========================================================
  // Operation codes from the execution logic
  typedef enum logic [3:0] {
    OP_NOP = 4'b0000,
    OP_FETCH = 4'b0001,
    OP_JUMP = 4'b0010,
    OP_LOAD = 4'b0011,
    OP_STORE = 4'b0100,
    OP_CODE_READ = 4'b0101,
    OP_PUSH = 4'b0110,
    OP_POP = 4'b0111,
    OP_POP_INT = 4'b1000
  } mpu_op_t;

  typedef enum logic [1:0] {
    PTR_DP0 = 2'b00,
    PTR_DP1 = 2'b01,
    PTR_FRAME = 2'b10
  } mpu_ptr_t;

  typedef enum logic [1:0] {
    STEP_NONE = 2'b00,
    STEP_INC = 2'b01,
    STEP_DEC = 2'b10
  } mpu_step_t;

  typedef enum logic [0:0] {
    ST_IDLE = 1'b0,
    ST_CODE_WAIT = 1'b1
  } mpu_state_t;

endpackage

// ---- verilog/mpu_core.sv ----
// Memory pointer unit: fetch address, data pointers, frame, code pointer, stack
`timescale 1ns/1ps
// ==========================================================
// Function
// - User program space 0000h-7FFFh, fetched via fetch address
// - Fetch address resets to 8000h, ROM start
// - Fetch address advances by one per fetch
// - Written fetch address used on next fetch
// - ROM code checks flag: loader or 0000h
// - Flag resets 0; JTAG sets it during hold
// - No write path into program memory
// - Word mode SRAM spans 0000h-03FFh
// - Pointer source reads SRAM, destination writes
// - Data pointers: post-step read, pre-step write
// - Frame address is base plus offset
// - Offset steps before write, after read
// - Offset carry never touches frame base
// - Code pointer: source only, post-step
// - SRAM pointer access takes one cycle
// - Code pointer read takes two cycles
// - Stack 16 bits wide, index resets 03F0h
// - Push: decrement index, then store
// - Pop: read at index, then increment
// - Pop with state also sets service bits
// - Word and byte access, all 16 bits decoded
// - Program pages mapped by mode and page select
// - Program in data space, page select upper bit 0
module mpu_core (
  // Clock and reset
  input wire logic REF_CLK,
  input wire logic RST,
  // Avalon-MM slave
  input wire logic [5:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [31:0] AVS_WRITEDATA,
  input wire logic [3:0] AVS_BYTEENABLE,
  output logic [31:0] AVS_READDATA,
  output logic AVS_WAITREQUEST,
  // Operation request from execution logic
  input wire logic OP_VALID,
  input wire logic [3:0] OP_CODE,
  input wire logic [1:0] OP_PTR,
  input wire logic [1:0] OP_STEP,
  input wire logic [15:0] OP_DATA,
  output logic OP_BUSY,
  output logic RES_VALID,
  output logic [15:0] RES_DATA,
  // Instruction fetch port
  output logic [15:0] FETCH_ADDR,
  output logic FETCH_STB,
  // Program memory data read port
  output logic [15:0] PM_ADDR,
  output logic PM_RE,
  input wire logic [15:0] PM_RDATA,
  // Data SRAM port
  output logic [15:0] SRAM_ADDR,
  output logic SRAM_RE,
  output logic SRAM_WE,
  output logic SRAM_BYTE,
  output logic [15:0] SRAM_WDATA,
  input wire logic [15:0] SRAM_RDATA,
  // Boot control and status
  input wire logic JTAG_SPE_REQ,
  input wire logic SYS_HOLD,
  output logic SYS_PROG_FLAG,
  output logic [1:0] INT_SERVICE
);

  // ==========================================================
  // State
  typedef struct packed {
    logic [15:0] ip;
    logic [15:0] dp0;
    logic [15:0] dp1;
    logic [15:0] bp;
    logic [15:0] frame_offset;
    logic [15:0] cp;
    logic [15:0] sp;
    logic word_mode;
    logic cda0;
    logic system_programming_flag;
    logic [1:0] interrupt_in_service_bits;
    logic jtag_s1;
    logic jtag_s2;
    logic hold_s1;
    logic hold_s2;
    mpu_pkg::mpu_state_t state;
    logic [1:0] cnt;
    logic busy;
    logic [15:0] fetch_addr;
    logic fetch_stb;
    logic [15:0] pm_addr;
    logic pm_re;
    logic pm_byte;
    logic pm_lane;
    logic [15:0] sram_addr;
    logic sram_re;
    logic sram_we;
    logic sram_byte;
    logic [15:0] sram_wdata;
    logic zero_pend;
    logic res_valid;
    logic [15:0] res_data;
    logic avs_wait;
    logic [31:0] avs_rdata;
  } mpu_st_t;

  mpu_st_t q;
  mpu_st_t d;

  // ==========================================================
  // Helpers
  function automatic logic [15:0] step_val(input logic [15:0] v, input logic [1:0] s);
    logic [15:0] r;
    r = v;
    if (s == mpu_pkg::STEP_INC) begin
      r = v + mpu_pkg::STEP_ONE;
    end else if (s == mpu_pkg::STEP_DEC) begin
      r = v - mpu_pkg::STEP_ONE;
    end
    return r;
  endfunction

  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] wd, input logic [3:0] be);
    logic [15:0] r;
    r = old;
    if (be[0]) begin
      r[7:0] = wd[7:0];
    end
    if (be[1]) begin
      r[15:8] = wd[15:8];
    end
    return r;
  endfunction

  function automatic logic sram_hit(input logic [15:0] a, input logic wm);
    logic r;
    r = wm ? (a <= mpu_pkg::SRAM_WORD_TOP) : (a <= mpu_pkg::SRAM_BYTE_TOP);
    return r;
  endfunction

  // ==========================================================
  // Next state
  logic take;
  logic [15:0] ptr_cur;
  logic [15:0] ptr_new;
  logic [15:0] acc_addr;
  logic [15:0] frame_addr;
  logic [15:0] cp_next;
  logic [15:0] sp_dec;
  logic [15:0] rd_word;
  logic [31:0] rd_mux;
  logic bus_wr;

  always_comb begin
    d = q;
    take = OP_VALID && !q.busy;
    frame_addr = q.bp + q.frame_offset;
    ptr_cur = q.dp0;
    rd_word = 16'h0000;
    rd_mux = 32'h0000_0000;
    bus_wr = 1'b0;
    case (mpu_pkg::mpu_ptr_t'(OP_PTR))
      mpu_pkg::PTR_DP0: ptr_cur = q.dp0;
      mpu_pkg::PTR_DP1: ptr_cur = q.dp1;
      mpu_pkg::PTR_FRAME: ptr_cur = q.frame_offset;
      default: ptr_cur = q.dp0;
    endcase
    ptr_new = step_val(ptr_cur, OP_STEP);
    cp_next = step_val(q.cp, OP_STEP);
    sp_dec = q.sp - mpu_pkg::STEP_ONE;
    // Load uses the old pointer, store the stepped one
    if (OP_CODE == mpu_pkg::OP_STORE) begin
      acc_addr = ptr_new;
    end else begin
      acc_addr = ptr_cur;
    end
    if (OP_PTR == mpu_pkg::PTR_FRAME) begin
      acc_addr = q.bp + acc_addr;
    end

    // Synchronisers
    d.jtag_s1 = JTAG_SPE_REQ;
    d.jtag_s2 = q.jtag_s1;
    d.hold_s1 = SYS_HOLD;
    d.hold_s2 = q.hold_s1;

    // One-cycle strobes
    d.fetch_stb = 1'b0;
    d.sram_re = 1'b0;
    d.sram_we = 1'b0;
    d.zero_pend = 1'b0;
    d.res_valid = 1'b0;

    // SRAM or out-of-range load result
    if (q.sram_re) begin
      d.res_valid = 1'b1;
      if (q.sram_byte) begin
        d.res_data = q.sram_addr[0] ? {8'h00, SRAM_RDATA[15:8]} : {8'h00, SRAM_RDATA[7:0]};
      end else begin
        d.res_data = SRAM_RDATA;
      end
    end else if (q.zero_pend) begin
      d.res_valid = 1'b1;
      d.res_data = 16'h0000;
    end

    case (q.state)
      mpu_pkg::ST_IDLE: begin
        if (take) begin
          case (mpu_pkg::mpu_op_t'(OP_CODE))
            mpu_pkg::OP_FETCH: begin
              d.fetch_addr = q.ip;
              d.fetch_stb = 1'b1;
              d.ip = q.ip + mpu_pkg::STEP_ONE;
            end
            mpu_pkg::OP_JUMP: begin
              d.ip = OP_DATA;
            end
            mpu_pkg::OP_LOAD, mpu_pkg::OP_STORE: begin
              if (sram_hit(acc_addr, q.word_mode)) begin
                d.sram_addr = acc_addr;
                d.sram_byte = !q.word_mode;
                d.sram_wdata = OP_DATA;
                d.sram_re = (OP_CODE == mpu_pkg::OP_LOAD);
                d.sram_we = (OP_CODE == mpu_pkg::OP_STORE);
              end else begin
                d.zero_pend = (OP_CODE == mpu_pkg::OP_LOAD);
              end
              case (mpu_pkg::mpu_ptr_t'(OP_PTR))
                mpu_pkg::PTR_DP0: d.dp0 = ptr_new;
                mpu_pkg::PTR_DP1: d.dp1 = ptr_new;
                mpu_pkg::PTR_FRAME: d.frame_offset = ptr_new;
                default: d.dp0 = q.dp0;
              endcase
            end
            mpu_pkg::OP_CODE_READ: begin
              // Word mode sees both pages, byte mode the selected page
              if (q.word_mode) begin
                d.pm_addr = {1'b0, q.cp[14:0]};
                d.pm_lane = 1'b0;
              end else begin
                d.pm_addr = {1'b0, q.cda0, q.cp[14:1]};
                d.pm_lane = q.cp[0];
              end
              d.pm_byte = !q.word_mode;
              d.pm_re = 1'b1;
              d.cp = cp_next;
              d.busy = 1'b1;
              d.cnt = mpu_pkg::CP_READ_CYCLES - 2'h1;
              d.state = mpu_pkg::ST_CODE_WAIT;
            end
            mpu_pkg::OP_PUSH: begin
              d.sp = sp_dec;
              d.sram_addr = sp_dec;
              d.sram_byte = 1'b0;
              d.sram_wdata = OP_DATA;
              d.sram_we = 1'b1;
            end
            mpu_pkg::OP_POP, mpu_pkg::OP_POP_INT: begin
              d.sram_addr = q.sp;
              d.sram_byte = 1'b0;
              d.sram_re = 1'b1;
              d.sp = q.sp + mpu_pkg::STEP_ONE;
              if (OP_CODE == mpu_pkg::OP_POP_INT) begin
                d.interrupt_in_service_bits = mpu_pkg::IPS_ACTIVE;
              end
            end
            default: begin
              d.busy = 1'b0;
            end
          endcase
        end
      end
      mpu_pkg::ST_CODE_WAIT: begin
        if (q.cnt == 2'h1) begin
          d.cnt = 2'h0;
        end else begin
          // Second cycle of program memory read done
          d.pm_re = 1'b0;
          d.busy = 1'b0;
          d.state = mpu_pkg::ST_IDLE;
          d.res_valid = 1'b1;
          if (q.pm_byte) begin
            d.res_data = q.pm_lane ? {8'h00, PM_RDATA[15:8]} : {8'h00, PM_RDATA[7:0]};
          end else begin
            d.res_data = PM_RDATA;
          end
        end
      end
      default: begin
        d.state = mpu_pkg::ST_IDLE;
        d.busy = 1'b0;
        d.pm_re = 1'b0;
      end
    endcase

    // Register read mux
    case (AVS_ADDRESS)
      mpu_pkg::OFS_FETCH: rd_word = q.ip;
      mpu_pkg::OFS_DP0: rd_word = q.dp0;
      mpu_pkg::OFS_DP1: rd_word = q.dp1;
      mpu_pkg::OFS_BASE: rd_word = q.bp;
      mpu_pkg::OFS_OFFSET: rd_word = q.frame_offset;
      mpu_pkg::OFS_CODE: rd_word = q.cp;
      mpu_pkg::OFS_STACK: rd_word = q.sp;
      mpu_pkg::OFS_FRAME: rd_word = frame_addr;
      mpu_pkg::OFS_STATUS: rd_word = {14'h0000, q.busy, q.state};
      mpu_pkg::OFS_CTRL: begin
        rd_word = 16'h0000;
        rd_word[mpu_pkg::CTRL_WORD_BIT] = q.word_mode;
        rd_word[mpu_pkg::CTRL_CDA0_BIT] = q.cda0;
        rd_word[mpu_pkg::CTRL_CDA1_BIT] = 1'b0;
        rd_word[mpu_pkg::CTRL_SPE_BIT] = q.system_programming_flag;
        rd_word[mpu_pkg::CTRL_IPS_LSB +: 2] = q.interrupt_in_service_bits;
      end
      default: rd_word = 16'h0000;
    endcase
    rd_mux = {16'h0000, rd_word};

    // Avalon handshake: wait one cycle, then answer
    if (q.avs_wait) begin
      if (AVS_READ || AVS_WRITE) begin
        d.avs_wait = 1'b0;
        d.avs_rdata = AVS_READ ? rd_mux : 32'h0000_0000;
      end
    end else begin
      d.avs_wait = 1'b1;
      bus_wr = AVS_WRITE;
    end

    // Bus writes override same-cycle pointer updates
    if (bus_wr) begin
      case (AVS_ADDRESS)
        mpu_pkg::OFS_FETCH: d.ip = merge16(q.ip, AVS_WRITEDATA, AVS_BYTEENABLE);
        mpu_pkg::OFS_DP0: d.dp0 = merge16(q.dp0, AVS_WRITEDATA, AVS_BYTEENABLE);
        mpu_pkg::OFS_DP1: d.dp1 = merge16(q.dp1, AVS_WRITEDATA, AVS_BYTEENABLE);
        mpu_pkg::OFS_BASE: d.bp = merge16(q.bp, AVS_WRITEDATA, AVS_BYTEENABLE);
        mpu_pkg::OFS_OFFSET: d.frame_offset = merge16(q.frame_offset, AVS_WRITEDATA, AVS_BYTEENABLE);
        mpu_pkg::OFS_CODE: d.cp = merge16(q.cp, AVS_WRITEDATA, AVS_BYTEENABLE);
        mpu_pkg::OFS_STACK: d.sp = merge16(q.sp, AVS_WRITEDATA, AVS_BYTEENABLE);
        mpu_pkg::OFS_CTRL: begin
          if (AVS_BYTEENABLE[0]) begin
            d.word_mode = AVS_WRITEDATA[mpu_pkg::CTRL_WORD_BIT];
            d.cda0 = AVS_WRITEDATA[mpu_pkg::CTRL_CDA0_BIT];
            if (!AVS_WRITEDATA[mpu_pkg::CTRL_SPE_BIT]) begin
              d.system_programming_flag = 1'b0;
            end
            if (!AVS_WRITEDATA[mpu_pkg::CTRL_IPS_LSB]) begin
              d.interrupt_in_service_bits[0] = 1'b0;
            end
            if (!AVS_WRITEDATA[mpu_pkg::CTRL_IPS_LSB + 1]) begin
              d.interrupt_in_service_bits[1] = 1'b0;
            end
          end
        end
        default: d.ip = d.ip;
      endcase
    end

    // Set wins over software clear
    if (take && q.state == mpu_pkg::ST_IDLE && OP_CODE == mpu_pkg::OP_POP_INT) begin
      d.interrupt_in_service_bits = mpu_pkg::IPS_ACTIVE;
    end
    if (q.jtag_s2 && q.hold_s2) begin
      d.system_programming_flag = 1'b1;
    end
  end

  // ==========================================================
  // Registers
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      q <= '0;
      q.ip <= mpu_pkg::IP_RESET;
      q.dp0 <= mpu_pkg::PTR_RESET;
      q.dp1 <= mpu_pkg::PTR_RESET;
      q.bp <= mpu_pkg::PTR_RESET;
      q.frame_offset <= mpu_pkg::PTR_RESET;
      q.cp <= mpu_pkg::PTR_RESET;
      q.sp <= mpu_pkg::SP_RESET;
      q.word_mode <= mpu_pkg::WORD_MODE_RESET;
      q.cda0 <= mpu_pkg::CDA0_RESET;
      q.system_programming_flag <= mpu_pkg::SPE_RESET;
      q.interrupt_in_service_bits <= mpu_pkg::IPS_RESET;
      q.state <= mpu_pkg::ST_IDLE;
      q.avs_wait <= 1'b1;
    end else begin
      q <= d;
    end
  end

  // ==========================================================
  // Outputs, program port is read only
  assign AVS_READDATA = q.avs_rdata;
  assign AVS_WAITREQUEST = q.avs_wait;
  assign OP_BUSY = q.busy;
  assign RES_VALID = q.res_valid;
  assign RES_DATA = q.res_data;
  assign FETCH_ADDR = q.fetch_addr;
  assign FETCH_STB = q.fetch_stb;
  assign PM_ADDR = q.pm_addr;
  assign PM_RE = q.pm_re;
  assign SRAM_ADDR = q.sram_addr;
  assign SRAM_RE = q.sram_re;
  assign SRAM_WE = q.sram_we;
  assign SRAM_BYTE = q.sram_byte;
  assign SRAM_WDATA = q.sram_wdata;
  assign SYS_PROG_FLAG = q.system_programming_flag;
  assign INT_SERVICE = q.interrupt_in_service_bits;

endmodule
